// ---- logic/dcs_pkg.sv ----
// Purpose: shared constants and types for the supply/sync/crystal config bank
// Assumes: 25 MHz system clock, APB with 32-bit data
// Notes: register offset is a free choice, no offset is printed
package dcs_pkg;
   localparam logic [11:0] DEV_CFG_ADDR = 12'h000;
   localparam int DOM_LSB = 20;
   localparam int DOM_MSB = 26;
   localparam int SYNC_LSB = 16;
   localparam int SYNC_MSB = 19;
   localparam int LDO_BIT = 15;
   localparam int XTAL_LSB = 12;
   localparam int XTAL_MSB = 14;
   localparam logic [6:0] DOM_RST = 7'h00;
   localparam logic [3:0] SYNC_RST = 4'h2;
   localparam logic [3:0] SYNC_MAX = 4'hC;
   localparam logic [2:0] XTAL_RST = 3'h0;
   localparam int SCAN_LDO_BIT = 6;
   localparam int CLK_MHZ = 25;
   localparam int US_CYCLES = CLK_MHZ;
   // crystal waits in units of 10 us
   localparam int XT_1MS = 100;
   localparam int XT_2P5MS = 250;
   localparam int XT_5MS = 500;
   localparam int XT_7P5MS = 750;
   localparam int XT_10MS = 1000;
   localparam int XT_0P5MS = 50;
   localparam int XT_15MS = 1500;
   localparam int XT_10US = 1;
   localparam int XT_UNIT_US = 10;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DONE = 2'b10
   } dcs_seq_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } dcs_apb_rsp_t;
endpackage : dcs_pkg

// ---- logic/dcs_wait_timer.sv ----
// Purpose: microsecond-tick wait timer with start and done
// Assumes: start is a one-cycle pulse; length in microseconds
// Notes: restart while busy reloads the count
`timescale 1ns/10ps
module dcs_wait_timer #(
   parameter int TICK_CYCLES = 25,
   parameter int LEN_W = 16
) (
   input wire logic clk_i,   // system clock
   input wire logic rst_n_i, // async reset
   input wire logic start_i, // begin wait
   input wire logic [LEN_W-1:0] len_us_i, // wait in us
   output logic done_o       // one-cycle completion pulse
);
   import dcs_pkg::*;
   typedef struct packed {
      dcs_seq_t st;
      logic [7:0] tick;
      logic [LEN_W-1:0] left;
      logic done;
   } dcs_tmr_t;
   dcs_tmr_t r, next_r;

   // tick lives in eight bits, length needs room to count down
   if (TICK_CYCLES < 1 || TICK_CYCLES > 256) begin : g_bad_tick
      $error("tick cycles out of range");
   end
   if (LEN_W < 2 || LEN_W > 32) begin : g_bad_len
      $error("length width out of range");
   end

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      if (start_i) begin
         next_r.st = ST_WAIT;
         next_r.tick = 8'(TICK_CYCLES - 1);
         next_r.left = len_us_i;
      end else if (r.st == ST_WAIT) begin
         if (r.tick != 8'h00) begin
            next_r.tick = r.tick - 8'h01;
         end else begin
            next_r.tick = 8'(TICK_CYCLES - 1);
            if (r.left <= LEN_W'(1)) begin
               next_r.st = ST_IDLE;
               next_r.done = 1'b1;
            end else begin
               next_r.left = r.left - LEN_W'(1);
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '{st: ST_IDLE, tick: 8'h00, left: '0, done: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign done_o = r.done;
endmodule : dcs_wait_timer

// ---- logic/dcs_config_bank.sv ----
// Purpose: device config bits 26:12 over APB, plus sync and crystal waits
// Assumes: APB slave, one wait state, word at DEV_CFG_ADDR
// Notes: other bits of the word read as zero here
// Notes on behaviour
// - seven domain disable bits sit at 26..20 for domains 6..0, reset 0.
// - a domain bit of 0 keeps its reference currents on, 1 turns them off.
// - sync drops affected output enables, waits, then stops and aligns.
// - the sync wait code gives 1us doubled per code up to 4096us, reset 2.
// - bit 15 picks regulator 1.25V or 1.32V, scan vector bit 6 overrides.
// - the crystal code picks the startup wait from the fixed table.
`timescale 1ns/10ps
module dcs_config_bank (
   input wire logic SYS_CLK_I,            // system clock 25 MHz
   input wire logic RST_N_I,              // async reset, active low
   input wire logic PSEL_I,               // apb select
   input wire logic PENABLE_I,            // apb enable
   input wire logic PWRITE_I,             // apb write
   input wire logic [11:0] PADDR_I,       // apb byte address
   input wire logic [31:0] PWDATA_I,      // apb write data
   input wire logic [3:0] PSTRB_I,        // apb byte strobes
   output logic [31:0] PRDATA_O,          // apb read data
   output logic PREADY_O,                 // apb ready
   output logic PSLVERR_O,                // apb error, unmapped address
   input wire logic SCAN_MODE_I,          // scan mode active
   input wire logic [7:0] SCAN_CTRL_I,    // scan control vector
   input wire logic SYNC_REQ_I,           // divider sync request pulse
   input wire logic [6:0] SYNC_DOM_I,     // domains affected by sync
   input wire logic XTAL_START_I,         // crystal wait start pulse
   output logic [6:0] IREF_DISABLE_O,     // per-domain reference off
   output logic [6:0] OUT_EN_O,           // per-domain driver enable
   output logic SYNC_ALIGN_O,             // stop clocks and align, pulse
   output logic XTAL_DONE_O,              // crystal wait done, pulse
   output logic LDO_HIGH_O                // regulator select, 1 = 1.32V
);
   import dcs_pkg::*;

   typedef struct packed {
      logic [6:0] dom_dis;
      logic [3:0] sync_wait;
      logic ldo_sel;
      logic [2:0] xtal_sel;
      dcs_apb_rsp_t rsp;
      dcs_seq_t sync_st;
      logic [6:0] out_en;
      logic align;
      logic xdone;
      logic ldo_out;
      logic [6:0] iref;
   } dcs_state_t;

   dcs_state_t r, next_r;
   logic sync_done, xtal_done, sync_start;
   logic [15:0] sync_len, xtal_len;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic logic [15:0] sync_us(input logic [3:0] code);
      logic [3:0] c;
      c = (code > SYNC_MAX) ? SYNC_MAX : code; // codes above C clamp
      sync_us = 16'h0001 << c;
   endfunction : sync_us

   function automatic logic [15:0] xtal_units(input logic [2:0] code);
      int v;
      case (code)
         3'h0: v = XT_1MS;
         3'h1: v = XT_2P5MS;
         3'h2: v = XT_5MS;
         3'h3: v = XT_7P5MS;
         3'h4: v = XT_10MS;
         3'h5: v = XT_0P5MS;
         3'h6: v = XT_15MS;
         default: v = XT_10US;
      endcase
      xtal_units = 16'(v);
   endfunction : xtal_units

   function automatic logic [31:0] read_word(input dcs_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[DOM_MSB:DOM_LSB] = s.dom_dis;
      w[SYNC_MSB:SYNC_LSB] = s.sync_wait;
      w[LDO_BIT] = s.ldo_sel;
      w[XTAL_MSB:XTAL_LSB] = s.xtal_sel;
      read_word = w;
   endfunction : read_word

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks: the field map must match the struct widths
   if (DOM_MSB - DOM_LSB != 6) begin : g_bad_dom
      $error("domain field must be seven bits wide");
   end
   if (SYNC_MSB - SYNC_LSB != 3) begin : g_bad_sync
      $error("sync wait field must be four bits wide");
   end
   if (XTAL_MSB - XTAL_LSB != 2) begin : g_bad_xtal
      $error("crystal field must be three bits wide");
   end
   if (SYNC_MSB >= DOM_LSB || LDO_BIT >= SYNC_LSB ||
       XTAL_MSB >= LDO_BIT || DOM_MSB > 31) begin : g_bad_order
      $error("config fields overlap or leave the word");
   end
   // both timers hold the tick count in eight bits
   if (US_CYCLES < 1 || US_CYCLES > 256) begin : g_bad_tick
      $error("microsecond tick out of range");
   end
   // longest crystal wait in us must fit the sixteen-bit timer length
   if (XT_15MS * XT_UNIT_US > 65535) begin : g_bad_xlen
      $error("crystal wait too long for the timer");
   end
   if (SYNC_RST > SYNC_MAX) begin : g_bad_srst
      $error("sync wait reset code beyond the table");
   end
   if (SCAN_LDO_BIT > 7) begin : g_bad_scan
      $error("scan override bit outside the scan vector");
   end
   // one word per register, so the offset must be word aligned
   if (DEV_CFG_ADDR[1:0] != 2'b00) begin : g_bad_addr
      $error("register offset not word aligned");
   end

   ////////////////////////////////////////////////////////////////////////
   // waits
   assign sync_start = (r.sync_st == ST_IDLE) && SYNC_REQ_I;
   assign sync_len = sync_us(r.sync_wait);
   assign xtal_len = 16'(32'(xtal_units(r.xtal_sel)) * XT_UNIT_US);

   dcs_wait_timer #(.TICK_CYCLES(US_CYCLES), .LEN_W(16)) u_sync_tmr (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .start_i(sync_start),
      .len_us_i(sync_len),
      .done_o(sync_done)
   );

   dcs_wait_timer #(.TICK_CYCLES(US_CYCLES), .LEN_W(16)) u_xtal_tmr (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .start_i(XTAL_START_I),
      .len_us_i(xtal_len),
      .done_o(xtal_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic hit;
      logic [31:0] wd;
      hit = 1'b0;
      wd = 32'h0000_0000;
      next_r = r;
      next_r.rsp.pready = 1'b0;
      next_r.rsp.pslverr = 1'b0;
      next_r.align = 1'b0;
      next_r.xdone = xtal_done;
      if (PADDR_I == DEV_CFG_ADDR) begin
         hit = 1'b1;
      end
      // one wait state: ready is registered off the first access edge
      if (PSEL_I && PENABLE_I && !r.rsp.pready) begin
         next_r.rsp.pready = 1'b1;
         next_r.rsp.pslverr = !hit;
         next_r.rsp.prdata = (hit && !PWRITE_I) ? read_word(r) : '0;
         if (hit && PWRITE_I) begin
            wd = read_word(r);
            for (int b = 0; b < 4; b++) begin
               if (PSTRB_I[b]) begin
                  wd[b*8 +: 8] = PWDATA_I[b*8 +: 8];
               end
            end
            next_r.dom_dis = wd[DOM_MSB:DOM_LSB];
            next_r.sync_wait = wd[SYNC_MSB:SYNC_LSB];
            next_r.ldo_sel = wd[LDO_BIT];
            next_r.xtal_sel = wd[XTAL_MSB:XTAL_LSB];
         end
      end
      // sync sequence: enables off, wait, then align
      case (r.sync_st)
         ST_IDLE: begin
            if (SYNC_REQ_I) begin
               next_r.out_en = r.out_en & ~SYNC_DOM_I;
               next_r.sync_st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (sync_done) begin
               next_r.align = 1'b1;
               next_r.out_en = 7'h7F;
               next_r.sync_st = ST_IDLE;
            end
         end
         default: begin
            next_r.sync_st = ST_IDLE;
         end
      endcase
      next_r.iref = next_r.dom_dis;
      next_r.ldo_out = SCAN_MODE_I ? SCAN_CTRL_I[SCAN_LDO_BIT]
                                   : next_r.ldo_sel;
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         r <= '{dom_dis: DOM_RST, sync_wait: SYNC_RST, ldo_sel: 1'b0,
                xtal_sel: XTAL_RST, rsp: '0, sync_st: ST_IDLE,
                out_en: 7'h7F, align: 1'b0, xdone: 1'b0, ldo_out: 1'b0,
                iref: DOM_RST};
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all registered
   assign PRDATA_O = r.rsp.prdata;
   assign PREADY_O = r.rsp.pready;
   assign PSLVERR_O = r.rsp.pslverr;
   assign IREF_DISABLE_O = r.iref;
   assign OUT_EN_O = r.out_en;
   assign SYNC_ALIGN_O = r.align;
   assign XTAL_DONE_O = r.xdone;
   assign LDO_HIGH_O = r.ldo_out;
endmodule : dcs_config_bank

// ---- testbench/dcs_config_bank_props.sv ----
// Purpose: port assertions for the config bank
// Assumes: one clock, async active-low reset
// Notes: bound from the bench file
`timescale 1ns/10ps
module dcs_props (
   input wire logic SYS_CLK_I, // clock
   input wire logic RST_N_I, // reset
   input wire logic PWRITE_I, // write
   input wire logic PREADY_O, // ready
   input wire logic SCAN_MODE_I, // scan
   input wire logic [7:0] SCAN_CTRL_I, // scan vector
   input wire logic SYNC_REQ_I, // sync request
   input wire logic [6:0] SYNC_DOM_I, // sync domains
   input wire logic XTAL_START_I, // crystal start
   input wire logic [6:0] IREF_DISABLE_O, // reference off
   input wire logic [6:0] OUT_EN_O, // enables
   input wire logic SYNC_ALIGN_O, // align
   input wire logic XTAL_DONE_O, // crystal done
   input wire logic LDO_HIGH_O // regulator
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   property p_rst;
      $rose(RST_N_I) |-> IREF_DISABLE_O == 7'h00 && !LDO_HIGH_O;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset value");
   property p_iref;
      $changed(IREF_DISABLE_O) |-> PREADY_O && PWRITE_I;
   endproperty
   a_iref: assert property (p_iref) else $error("stray change");
   property p_oen;
      SYNC_REQ_I && OUT_EN_O == 7'h7f |=> OUT_EN_O == ~$past(SYNC_DOM_I);
   endproperty
   a_oen: assert property (p_oen) else $error("enables not dropped");
   // shortest code is 1 us, so enables stay low at least 20 cycles
   property p_wait; SYNC_ALIGN_O |-> $past(OUT_EN_O, 20) != 7'h7f; endproperty
   a_wait: assert property (p_wait) else $error("align too early");
   property p_ldo;
      SCAN_MODE_I && $past(SCAN_MODE_I)
         |-> LDO_HIGH_O == $past(SCAN_CTRL_I[6]);
   endproperty
   a_ldo: assert property (p_ldo) else $error("scan not obeyed");
   property p_xtal; XTAL_START_I |=> !XTAL_DONE_O [*8]; endproperty
   a_xtal: assert property (p_xtal) else $error("crystal too fast");
   property p_done; XTAL_DONE_O |=> !XTAL_DONE_O; endproperty
   a_done: assert property (p_done) else $error("done not a pulse");
   property p_align;
      SYNC_ALIGN_O |=> !SYNC_ALIGN_O && OUT_EN_O == 7'h7f;
   endproperty
   a_align: assert property (p_align) else $error("align end bad");
endmodule : dcs_props

// ---- testbench/dcs_config_bank_bench.sv ----
// Purpose: self-checking bench for the config bank
// Assumes: register word at offset zero
// Notes: apb answers are checked by a monitor from a queue
`timescale 1ns/10ps
module dcs_config_bank_bench;
   import dcs_pkg::*;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, scm = 0;
   logic sreq = 0, xst = 0, prdy, perr, algn, xdone, ldo;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, w, v = 32'h0000_cbfa;
   logic [7:0] sctl = 8'h00;
   logic [3:0] pstrb = 4'hf;
   logic [6:0] sdom = 7'h00, iref, oen;
   logic [33:0] e;
   logic [33:0] exq[$];
   logic [2:0] xc[3] = '{3'h7, 3'h5, 3'h0};
   int xt_cyc[8] = '{25000, 62500, 125000, 187500, 250000, 12500, 375000, 250};
   int fails = 0, samples_checked = 0;
   initial forever #20 clk = ~clk;
   dcs_config_bank dut_u (.SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(prdy), .PSLVERR_O(perr),
      .SCAN_MODE_I(scm), .SCAN_CTRL_I(sctl), .SYNC_REQ_I(sreq),
      .SYNC_DOM_I(sdom), .XTAL_START_I(xst), .IREF_DISABLE_O(iref),
      .OUT_EN_O(oen), .SYNC_ALIGN_O(algn), .XTAL_DONE_O(xdone),
      .LDO_HIGH_O(ldo));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         fails++;
         $display("[FAIL] %0t port %h exp %h", $time, g, x);
      end
   endtask : chk
   task automatic chk_apb(input logic [32:0] g, input logic [32:0] x);
      samples_checked++;
      if (g !== x) begin
         fails++;
         $display("[FAIL] %0t apb %h exp %h", $time, g, x);
      end
   endtask : chk_apb
   // note: {check data, error, data}
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, input logic [33:0] x);
      exq.push_back(x);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // no cycle count assumed: only the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   // pulse a start, then count cycles to the answer
   task automatic timed(input logic x, input int ex);
      int n;
      n = 0;
      @(posedge clk);
      if (x) xst <= 1'b1;
      else sreq <= 1'b1;
      @(posedge clk);
      xst <= 1'b0;
      sreq <= 1'b0;
      @(posedge clk);
      if (!x) chk({25'h0, oen}, {25'h0, ~sdom});
      while ((x ? xdone : algn) !== 1'b1 && n < 30000) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n >= ex - 3 && n <= ex + 6), 32'h1);
   endtask : timed
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (prdy === 1'b1) begin
         e = exq.pop_front();
         chk_apb({perr, prdata & {32{e[33]}}}, e[32:0]);
      end
   end
   initial begin
      #(60000 * 40);
      fails++;
      give_verdict;
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, 12'h000, 32'h0, {2'b10, 32'h0002_0000});
      chk({25'h0, iref}, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         v = lfsr(v);
         w = {5'h00, v[6:0], v[11:8], v[7], v[14:12], 12'h000};
         apb(1'b1, 12'h000, w, 34'h0);
         apb(1'b0, 12'h000, w, {2'b10, w});
         chk({24'h0, ldo, iref}, {24'h0, w[15], w[26:20]});
      end
      // unmapped word: refused, register untouched
      apb(1'b1, 12'h004, 32'hffff_ffff, {2'b01, 32'h0});
      apb(1'b0, 12'h004, 32'h0, {2'b11, 32'h0});
      apb(1'b0, 12'h000, 32'h0, {2'b10, w});
      // byte strobes: only byte 2 lands
      pstrb <= 4'h4;
      apb(1'b1, 12'h000, 32'hffff_ffff, 34'h0);
      pstrb <= 4'hf;
      apb(1'b0, 12'h000, 32'h0, {2'b10, w[31:24], 8'hff, w[15:0]});
      chk({25'h0, iref}, {25'h0, w[26:24], 4'hf});
      $display("test register done");
      scm <= 1'b1;
      for (int b = 0; b < 2; b++) begin
         @(posedge clk);
         sctl <= {1'b0, b[0], 6'h2a};
         repeat (2) @(posedge clk);
         chk({31'h0, ldo}, {31'h0, b[0]});
      end
      scm <= 1'b0;
      $display("test scan done");
      for (int c = 0; c < 3; c++) begin
         v = lfsr(v);
         sdom <= v[6:0] | 7'h01;
         apb(1'b1, 12'h000, {12'h000, 4'(c), 16'h0000}, 34'h0);
         timed(1'b0, 25 << c);
      end
      $display("test sync done");
      foreach (xc[k]) begin
         apb(1'b1, 12'h000, {17'h0, xc[k], 12'h000}, 34'h0);
         timed(1'b1, xt_cyc[xc[k]]);
      end
      $display("test crystal done");
      give_verdict;
   end
endmodule : dcs_config_bank_bench
bind dcs_config_bank dcs_props chk_u (
   .SYS_CLK_I(SYS_CLK_I),
   .RST_N_I(RST_N_I),
   .PWRITE_I(PWRITE_I),
   .PREADY_O(PREADY_O),
   .SCAN_MODE_I(SCAN_MODE_I),
   .SCAN_CTRL_I(SCAN_CTRL_I),
   .SYNC_REQ_I(SYNC_REQ_I),
   .SYNC_DOM_I(SYNC_DOM_I),
   .XTAL_START_I(XTAL_START_I),
   .IREF_DISABLE_O(IREF_DISABLE_O),
   .OUT_EN_O(OUT_EN_O),
   .SYNC_ALIGN_O(SYNC_ALIGN_O),
   .XTAL_DONE_O(XTAL_DONE_O),
   .LDO_HIGH_O(LDO_HIGH_O)
);
